// ===== inc/pwp_defines.vh
/*
 * Register offsets, field positions and reset value of the peripheral write-protect bank.
 * Assumes inclusion by bare name from design files that need these constants.
 */
`ifndef PWP_DEFINES_VH
`define PWP_DEFINES_VH

`define PWP_ADDR_W     8
`define PWP_OFS_CLEAR  8'h00
`define PWP_OFS_SET    8'h04
`define PWP_RESET      32'h00800000
`define PWP_EVS_BIT    1
`define PWP_SER_LSB    2
`define PWP_TC_LSB     8
`define PWP_ANA_LSB    16
`define PWP_TC_W       8
`define PWP_SER_W      6
`define PWP_ANA_W      4
`define PWP_ADC_BIT    16
`define PWP_CMP_BIT    17
`define PWP_DAC_BIT    18
`define PWP_TOUCH_BIT  19
`define PWP_TC_ONES    32'h000000FF
`define PWP_SER_ONES   32'h0000003F
`define PWP_ANA_ONES   32'h0000000F
`define PWP_ONE        32'h00000001
`define PWP_MASK       ((`PWP_TC_ONES << `PWP_TC_LSB) | (`PWP_SER_ONES << `PWP_SER_LSB) | \
                        (`PWP_ONE << `PWP_EVS_BIT) | (`PWP_ANA_ONES << `PWP_ANA_LSB))

`endif

// ===== verilog/pwp_gate.v
/*
 * Write gate: answers each peripheral write request with pass or error one cycle later.
 * Assumes the request comes from logic on the same clock and the flag vector is registered.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwp_defines.vh"

module pwp_gate (
    input  wire        clk_sys_in,
    input  wire        rstn_in,
    input  wire        wr_in,
    input  wire [4:0]  idx_in,
    input  wire [31:0] flags_in,
    output reg         ok_out,
    output reg         err_out
);

    wire [31:0] impl;
    wire        prot;

    // Indices with no mapped flag are never protected.
    assign impl = `PWP_MASK;
    assign prot = flags_in[idx_in] & impl[idx_in];

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ok_out  <= 1'b0;
            err_out <= 1'b0;
        end else begin
            ok_out  <= wr_in & ~prot;
            err_out <= wr_in & prot;
        end
    end

endmodule // pwp_gate

`default_nettype wire

// ===== verilog/pwp_bank.v
/*
 * Peripheral write-protect bank: clear/set register pair on the peripheral bus, flag vector,
 * and write gate for the peripherals behind the same bridge.
 * Assumes a zero-wait peripheral bus master on clk_sys_in and peripherals that honour the gate.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwp_defines.vh"

module pwp_bank (
    input  wire                  clk_sys_in,
    input  wire                  rstn_in,
    input  wire                  psel_in,
    input  wire                  penable_in,
    input  wire                  pwrite_in,
    input  wire [`PWP_ADDR_W-1:0] paddr_in,
    input  wire [31:0]           pwdata_in,
    input  wire [3:0]            pstrb_in,
    output reg  [31:0]           prdata_out,
    output wire                  pready_out,
    output wire                  pslverr_out,
    input  wire                  per_wr_in,
    input  wire [4:0]            per_idx_in,
    output wire                  per_wr_ok_out,
    output wire                  per_wr_err_out,
    output wire [31:0]           protect_flags_out,
    output wire [7:0]            timer_counter_flags_out,
    output wire [5:0]            serial_unit_flags_out,
    output wire                  event_system_flag_out,
    output wire                  adc_flag_out,
    output wire                  comparator_flag_out,
    output wire                  dac_flag_out,
    output wire                  touch_unit_flag_out
);

    // The reset word has a one at bit 23, where no flag exists, so every flag comes up clear.
    localparam [31:0] RST_WORD = `PWP_RESET;

    reg  [`PWP_TC_W-1:0]  tmr_flags_r;
    reg  [`PWP_TC_W-1:0]  tmr_flags_nxt;
    reg  [`PWP_SER_W-1:0] ser_flags_r;
    reg  [`PWP_SER_W-1:0] ser_flags_nxt;
    reg                   evs_flag_r;
    reg                   evs_flag_nxt;
    reg  [`PWP_ANA_W-1:0] ana_flags_r;
    reg  [`PWP_ANA_W-1:0] ana_flags_nxt;
    reg  [31:0]           rd_word;
    wire [31:0]           flags;
    wire [31:0]           lanes;
    wire [31:0]           wmask;
    wire [31:0]           upd_word;
    wire                  acc;
    wire                  setup_rd;
    wire                  hit_clr;
    wire                  hit_set;
    wire                  mapped;
    wire                  dbl;
    wire                  err;
    wire                  upd;

    function [31:0] strb_mask;
        input [3:0] s;
        begin
            strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    function is_reg;
        input [`PWP_ADDR_W-1:0] a;
        input [`PWP_ADDR_W-1:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    // Unused bits have no flop behind them, so they read zero without any masking.
    function [31:0] pack_flags;
        input [`PWP_TC_W-1:0]  tmr;
        input [`PWP_SER_W-1:0] ser;
        input                  evs;
        input [`PWP_ANA_W-1:0] ana;
        begin
            pack_flags                             = 32'h00000000;
            pack_flags[`PWP_TC_LSB +: `PWP_TC_W]   = tmr;
            pack_flags[`PWP_SER_LSB +: `PWP_SER_W] = ser;
            pack_flags[`PWP_EVS_BIT]               = evs;
            pack_flags[`PWP_ANA_LSB +: `PWP_ANA_W] = ana;
        end
    endfunction

    function redundant;
        input        set;
        input [31:0] w;
        input [31:0] cur;
        begin
            if (set) begin
                redundant = |(w & cur);
            end else begin
                redundant = |(w & ~cur);
            end
        end
    endfunction

    function [31:0] apply_word;
        input        set;
        input [31:0] w;
        input [31:0] cur;
        begin
            if (set) begin
                apply_word = cur | w;
            end else begin
                apply_word = cur & ~w;
            end
        end
    endfunction

    assign acc      = psel_in & penable_in;
    assign setup_rd = psel_in & ~penable_in & ~pwrite_in;
    assign hit_clr  = is_reg(paddr_in, `PWP_OFS_CLEAR);
    assign hit_set  = is_reg(paddr_in, `PWP_OFS_SET);
    assign mapped   = hit_clr | hit_set;

    assign flags = pack_flags(tmr_flags_r, ser_flags_r, evs_flag_r, ana_flags_r);

    // Only strobed lanes of implemented bits carry a one; zeros never act.
    assign lanes = strb_mask(pstrb_in);
    assign wmask = pwdata_in & lanes & `PWP_MASK;

    // A whole write is refused if any of its ones would be a no-op, so software sees
    // its program-flow slip instead of a partial update.
    assign dbl      = redundant(hit_set, wmask, flags);
    assign err      = acc & (~mapped | (pwrite_in & dbl));
    assign upd      = acc & pwrite_in & mapped & ~dbl;
    assign upd_word = apply_word(hit_set, wmask, flags);

    assign pready_out  = 1'b1;
    assign pslverr_out = err;

    always @* begin
        tmr_flags_nxt = tmr_flags_r;
        if (upd) begin
            tmr_flags_nxt = upd_word[`PWP_TC_LSB +: `PWP_TC_W];
        end
    end

    always @* begin
        ser_flags_nxt = ser_flags_r;
        if (upd) begin
            ser_flags_nxt = upd_word[`PWP_SER_LSB +: `PWP_SER_W];
        end
    end

    always @* begin
        evs_flag_nxt = evs_flag_r;
        if (upd) begin
            evs_flag_nxt = upd_word[`PWP_EVS_BIT];
        end
    end

    always @* begin
        ana_flags_nxt = ana_flags_r;
        if (upd) begin
            ana_flags_nxt = upd_word[`PWP_ANA_LSB +: `PWP_ANA_W];
        end
    end

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tmr_flags_r <= RST_WORD[`PWP_TC_LSB +: `PWP_TC_W];
        end else begin
            tmr_flags_r <= tmr_flags_nxt;
        end
    end

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ser_flags_r <= RST_WORD[`PWP_SER_LSB +: `PWP_SER_W];
        end else begin
            ser_flags_r <= ser_flags_nxt;
        end
    end

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            evs_flag_r <= RST_WORD[`PWP_EVS_BIT];
        end else begin
            evs_flag_r <= evs_flag_nxt;
        end
    end

    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ana_flags_r <= RST_WORD[`PWP_ANA_LSB +: `PWP_ANA_W];
        end else begin
            ana_flags_r <= ana_flags_nxt;
        end
    end

    always @* begin
        case (paddr_in)
            `PWP_OFS_CLEAR: begin
                rd_word = flags;
            end
            `PWP_OFS_SET: begin
                rd_word = flags;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // Read data is captured in the setup phase so the access phase needs no wait state.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h00000000;
        end else if (setup_rd) begin
            prdata_out <= rd_word;
        end
    end

    assign protect_flags_out       = flags;
    assign timer_counter_flags_out = tmr_flags_r;
    assign serial_unit_flags_out   = ser_flags_r;
    assign event_system_flag_out   = evs_flag_r;
    assign adc_flag_out            = ana_flags_r[`PWP_ADC_BIT - `PWP_ANA_LSB];
    assign comparator_flag_out     = ana_flags_r[`PWP_CMP_BIT - `PWP_ANA_LSB];
    assign dac_flag_out            = ana_flags_r[`PWP_DAC_BIT - `PWP_ANA_LSB];
    assign touch_unit_flag_out     = ana_flags_r[`PWP_TOUCH_BIT - `PWP_ANA_LSB];

    pwp_gate u_gate (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .wr_in      (per_wr_in),
        .idx_in     (per_idx_in),
        .flags_in   (flags),
        .ok_out     (per_wr_ok_out),
        .err_out    (per_wr_err_out)
    );

endmodule // pwp_bank

`default_nettype wire

// ===== tb/pwp_bank_asserts.sv
/* Checker for the pwp_bank ports.
   Assumes one clock and a bus master that waits for pready. */
`timescale 1ns/1ps
`default_nettype none
module pwp_chk (
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic        pslverr_out,
    input wire logic        per_wr_in,
    input wire logic        per_wr_ok_out,
    input wire logic        per_wr_err_out,
    input wire logic [7:0]  paddr_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [4:0]  per_idx_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] protect_flags_out
);
    wire logic        wr = psel_in & penable_in & pwrite_in;
    wire logic [31:0] fl = protect_flags_out;
    wire logic [31:0] ef = pwdata_in & 32'h000FFFFE & {{8{pstrb_in[3]}}, {8{pstrb_in[2]}},
                           {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_unmapped_err: assert property (psel_in && penable_in && paddr_in != 8'h00 &&
        paddr_in != 8'h04 |-> pslverr_out) else $error("unmapped access taken");
    a_set_raise: assert property (wr && paddr_in == 8'h04 && !pslverr_out |=>
        fl == ($past(fl) | $past(ef))) else $error("set write wrong");
    a_clear_drop: assert property (wr && paddr_in == 8'h00 && !pslverr_out |=>
        fl == ($past(fl) & ~$past(ef))) else $error("clear write wrong");
    a_double_err: assert property (wr && (paddr_in == 8'h04 ? |(ef & fl) :
        paddr_in == 8'h00 && |(ef & ~fl)) |-> pslverr_out) else $error("double not refused");
    a_err_keep: assert property (wr && pslverr_out |=> $stable(fl)) else $error("refused write");
    a_idle_keep: assert property (!wr |=> $stable(fl)) else $error("flags moved");
    a_gate_err: assert property (per_wr_in && fl[per_idx_in] |=>
        per_wr_err_out && !per_wr_ok_out) else $error("protected write passed");
    a_gate_ok: assert property (per_wr_in && !fl[per_idx_in] |=>
        per_wr_ok_out && !per_wr_err_out) else $error("free write refused");
    a_map_zero: assert property (fl[31:20] == 12'h000 && !fl[0]) else $error("stray flag");
endmodule // pwp_chk
bind pwp_bank pwp_chk u_pwp_chk (.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
    .pslverr_out, .per_wr_in, .per_wr_ok_out, .per_wr_err_out, .paddr_in, .pstrb_in,
    .per_idx_in, .pwdata_in, .protect_flags_out);
`default_nettype wire

// ===== tb/pwp_cpu.sv
/* Processor model on the peripheral bus.
   Assumes a slave that answers with pready on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module pwp_cpu (
    input wire logic         clk_sys_in,
    input wire logic         pready_in,
    input wire logic         pslverr_in,
    input wire logic  [31:0] prdata_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [7:0]  paddr_out,
    output logic      [3:0]  pstrb_out,
    output logic      [31:0] pwdata_out
);
    initial {psel_out, penable_out, pwrite_out, paddr_out, pstrb_out, pwdata_out} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e);
        @(negedge clk_sys_in);
        {psel_out, pwrite_out, paddr_out, pwdata_out, pstrb_out} = {1'b1, w, a, d, s};
        @(negedge clk_sys_in) penable_out = 1'b1;
        @(posedge clk_sys_in iff pready_in);
        q = prdata_in;
        e = pslverr_in;
        @(negedge clk_sys_in);
        // Released data is inverted so a stale value never looks live.
        {psel_out, penable_out, pwdata_out} = {2'b00, ~d};
    endtask
endmodule // pwp_cpu
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench for pwp_bank.
   Assumes the processor model and the checker bound by name. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys_in = 1'b0, rstn_in = 1'b0, per_wr_in = 1'b0;
    logic        ps, pe, pw, rdy, err, ok, perr, e;
    logic [7:0]  ad;
    logic [3:0]  sb;
    logic [4:0]  per_idx_in = 5'h00;
    logic [31:0] wd, rd_d, fl, q;
    logic [7:0]  tcf;
    logic [5:0]  srf;
    logic        evf, adf, cmf, daf, tuf;
    int          n_mismatch = 0, checked = 0, cyc = 0;
    initial forever #2 clk_sys_in = ~clk_sys_in;
    pwp_cpu u_pwp_cpu (.clk_sys_in, .pready_in(rdy), .pslverr_in(err), .prdata_in(rd_d),
        .psel_out(ps), .penable_out(pe), .pwrite_out(pw), .paddr_out(ad), .pstrb_out(sb),
        .pwdata_out(wd));
    pwp_bank u_pwp_bank (.clk_sys_in, .rstn_in, .psel_in(ps), .penable_in(pe), .pwrite_in(pw),
        .paddr_in(ad), .pwdata_in(wd), .pstrb_in(sb), .prdata_out(rd_d), .pready_out(rdy),
        .pslverr_out(err), .per_wr_in, .per_idx_in, .per_wr_ok_out(ok), .per_wr_err_out(perr),
        .protect_flags_out(fl), .timer_counter_flags_out(tcf), .serial_unit_flags_out(srf),
        .event_system_flag_out(evf), .adc_flag_out(adf), .comparator_flag_out(cmf),
        .dac_flag_out(daf), .touch_unit_flag_out(tuf));
    task chk(input string n, input logic [31:0] s, x);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task wrs(input logic [3:0] s, input logic [7:0] a, input logic [31:0] d, input logic x);
        u_pwp_cpu.xfer(1'b1, a, d, s, q, e);
        chk("slverr", {31'h0, e}, {31'h0, x});
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic x);
        wrs(4'hF, a, d, x);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        u_pwp_cpu.xfer(1'b0, a, 32'h0, 4'h0, q, e);
        chk("rdata", q, x);
    endtask
    // The gate answer stands for one cycle only, so it is read before the request drops.
    task gate(input logic [4:0] i, input logic x);
        @(negedge clk_sys_in) {per_wr_in, per_idx_in} = {1'b1, i};
        @(negedge clk_sys_in) chk("gate", {30'h0, perr, ok}, x ? 32'h2 : 32'h1);
        per_wr_in = 1'b0;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        rd(8'h00, 32'h0);
        for (int b = 1; b < 20; b++) begin
            wr(8'h04, 32'h1 << b, 1'b0);
            rd(8'h00, 32'h1 << b);
            chk("flags", fl, 32'h1 << b);
            chk("map", {12'h0, tuf, daf, cmf, adf, tcf, srf, evf, 1'b0}, 32'h1 << b);
            chk("ready", {31'h0, rdy}, 32'h1);
            gate(5'(b), 1'b1);
            wr(8'h04, 32'h1 << b, 1'b1);
            wr(8'h00, 32'h1 << b, 1'b0);
            wr(8'h00, 32'h1 << b, 1'b1);
            rd(8'h04, 32'h0);
        end
        $display("test walk done");
        wr(8'h04, 32'hFFF00101, 1'b0);
        wr(8'h04, 32'h0000030F, 1'b1);
        wr(8'h00, 32'h0, 1'b0);
        rd(8'h04, 32'h00000100);
        gate(5'd9, 1'b0);
        gate(5'd0, 1'b0);
        gate(5'd20, 1'b0);
        wr(8'h08, 32'h2, 1'b1);
        rd(8'h00, 32'h00000100);
        rd(8'h08, 32'h0);
        $display("test guard done");
        wrs(4'h1, 8'h04, 32'h00000300, 1'b0);
        wrs(4'h4, 8'h04, 32'h000F0100, 1'b0);
        rd(8'h00, 32'h000F0100);
        chk("analog", {28'h0, tuf, daf, cmf, adf}, 32'hF);
        $display("test strobe done");
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        rd(8'h04, 32'h0);
        chk("flags", fl, 32'h0);
        $display("test reset done");
        close_out();
    end
    always @(posedge clk_sys_in) if (++cyc == 3000) begin
        n_mismatch++;
        close_out();
    end
endmodule // tb
`default_nettype wire
